// ---- include/pia_defines.svh ----
// Constants of the interrupt source aggregator: bit positions, edge sets, reset values, timing
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH
// ---------------------------------------------
// Bit positions, event group one
// ---------------------------------------------
`define PIA_B_VSYS 6
`define PIA_B_HOT 5
`define PIA_B_PDN 4
`define PIA_B_RWAKE 3
`define PIA_B_HOLD 2
`define PIA_B_PWR 1
// ---------------------------------------------
// Bit positions, event groups two and three
// ---------------------------------------------
`define PIA_B_SHORT 6
`define PIA_B_RSTIN 4
`define PIA_B_WDOG 2
`define PIA_B_TICK 1
`define PIA_B_ALARM 0
`define PIA_B_VBUS 7
`define PIA_B_ADCSW 2
`define PIA_B_CMP1 1
`define PIA_B_CMP0 0
// ---------------------------------------------
// Per-group sets: implemented, rising, falling, wake-capable
// ---------------------------------------------
`define PIA_USED_G1 8'h7E
`define PIA_USED_G2 8'h57
`define PIA_USED_G3 8'h87
`define PIA_RISE_G1 8'h74
`define PIA_FALL_G1 8'h7A
`define PIA_RISE_G2 8'h57
`define PIA_RISE_G3 8'h87
`define PIA_FALL_G3 8'h80
`define PIA_WAKE_G2 8'h43
`define PIA_WAKE_G3 8'h87
`define PIA_ALWAYS_G1 8'h0A
`define PIA_ONLY_ON_G1 8'h2A
// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
`define PIA_STATUS_RST 8'h00
`define PIA_CLK_HZ 20000000
`define PIA_HOLD_STEP_MS 1000
`endif

// ---- include/pia_pkg.sv ----
// Types shared by the interrupt source aggregator
package pia_pkg;
    // Power state of the device as seen by the aggregator
    typedef enum logic [1:0] {PS_OFF, PS_ACTIVE, PS_SLEEP} pia_pstate_t;
    // Four event groups of eight bits
    typedef logic [3:0][7:0] pia_grp_t;
    // Configuration bits steering the block
    typedef struct packed {
        logic int_active_high;
        logic clear_on_write;
        logic pending_en;
        logic rtc_tick_en;
        logic [1:0] hold_delay_setting;
        logic [1:0] cmp_below;
        pia_grp_t mask;
        logic [7:0] gpio_rise_en;
        logic [7:0] gpio_fall_en;
    } pia_cfg_t;
    // One status register access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } pia_req_t;
endpackage : pia_pkg

// ---- rtl/pia_aggregator.sv ----
// Interrupt source aggregator: edge detection, four status groups, one interrupt line and a wake request
`timescale 1ns/1ns
`include "pia_defines.svh"

// What this block does
// - Supply watch both edges, group one bit 6
// - Overheat both edges, bit 5, not when off
// - Power-down pin both edges, bit 4
// - Remote wake falling, bit 3, wakes even when masked, not when off
// - Button held past delay sets bit 2
// - Button falling, bit 1, wakes even when masked, not when off
// - Short rising, group two bit 6
// - Reset pin rising, group two bit 4
// - Watchdog expiry rising, group two bit 2
// - Clock tick rising, bit 1, enable off
// - Calendar alarm rising, group two bit 0
// - Bus-voltage comparator both edges, group three bit 7
// - ADC software result, group three bit 2
// - ADC comparisons, bits 1 and 0, direction selectable
// - GPIO pins onto group four, selectable edges
// - All status ORed onto one polar line
// - Masked source detects nothing, old bit stays
// - Clear on read whole register, or per-bit write
// - One pending repeat per source, or discard
module pia_aggregator
    import pia_pkg::*;
#(
    parameter int unsigned HOLD_STEP_CYC = `PIA_HOLD_STEP_MS * (`PIA_CLK_HZ / 1000)
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Device state and configuration
    input wire pia_pstate_t power_state,
    input wire pia_cfg_t cfg,
    // Internal and pin event sources
    input wire logic supply_voltage_watch,
    input wire logic die_overheat,
    input wire logic power_down_pin,
    input wire logic remote_wake_pin,
    input wire logic power_button,
    input wire logic short_any,
    input wire logic reset_in_pin,
    input wire logic watchdog_expiry,
    input wire logic rtc_tick,
    input wire logic rtc_alarm,
    input wire logic vbus_wake,
    input wire logic adc_sw_done,
    input wire logic [1:0] adc_cmp_above,
    input wire logic [7:0] gpio_pins,
    // Status register access
    input wire pia_req_t req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Host line and sequencer request
    output logic int_line,
    output logic wake_request
);
    // ---------------------------------------------
    // Elaboration check
    // ---------------------------------------------
    // The hold limit is (setting + 1) steps in a 32-bit count, so a step must fit four times
    if (HOLD_STEP_CYC < 1 || HOLD_STEP_CYC > 32'h3FFFFFFF)
    begin : g_chk
        $error("HOLD_STEP_CYC must be at least one cycle and at most a quarter of the counter range");
    end

    // ---------------------------------------------
    // Storage
    // ---------------------------------------------
    pia_grp_t status_r; // Sticky event bits
    pia_grp_t pend_r; // One stored repeat per source
    pia_grp_t prev_r; // Previous level of every source
    logic armed_r; // Blocks false edges in the first cycle after reset
    logic [31:0] hold_cnt_r; // Cycles the button has been low
    logic last_valid_r; // A register access has happened
    logic [1:0] last_sel_r; // Register touched by the last access
    logic int_line_r;
    logic wake_r;
    logic [7:0] rdata_r;
    logic rvalid_r;

    // ---------------------------------------------
    // Source levels
    // ---------------------------------------------
    pia_grp_t lvl; // Current level of every source
    logic hold_hit; // Button held beyond the delay
    logic [31:0] hold_limit;
    logic is_on;
    assign is_on = (power_state != PS_OFF);
    assign hold_limit = 32'((32'(cfg.hold_delay_setting) + 32'd1) * HOLD_STEP_CYC);
    assign hold_hit = (hold_cnt_r >= hold_limit);

    // Assemble levels; unused bits stay low
    always_comb
    begin
        lvl = '0;
        lvl[0][`PIA_B_VSYS] = supply_voltage_watch;
        lvl[0][`PIA_B_HOT] = die_overheat;
        lvl[0][`PIA_B_PDN] = power_down_pin;
        lvl[0][`PIA_B_RWAKE] = remote_wake_pin;
        lvl[0][`PIA_B_HOLD] = hold_hit;
        lvl[0][`PIA_B_PWR] = power_button;
        lvl[1][`PIA_B_SHORT] = short_any;
        lvl[1][`PIA_B_RSTIN] = reset_in_pin;
        lvl[1][`PIA_B_WDOG] = watchdog_expiry;
        lvl[1][`PIA_B_TICK] = rtc_tick & cfg.rtc_tick_en;
        lvl[1][`PIA_B_ALARM] = rtc_alarm;
        lvl[2][`PIA_B_VBUS] = vbus_wake;
        lvl[2][`PIA_B_ADCSW] = adc_sw_done;
        lvl[2][`PIA_B_CMP1] = adc_cmp_above[1] ^ cfg.cmp_below[1];
        lvl[2][`PIA_B_CMP0] = adc_cmp_above[0] ^ cfg.cmp_below[0];
        lvl[3] = gpio_pins;
    end

    // ---------------------------------------------
    // Edge selection and qualification
    // ---------------------------------------------
    pia_grp_t rise_en;
    pia_grp_t fall_en;
    pia_grp_t used;
    pia_grp_t wake_cap;
    pia_grp_t state_en; // Sources silenced while off
    pia_grp_t edge_raw; // Raw edges before masking
    pia_grp_t evt; // Qualified events
    assign rise_en = {cfg.gpio_rise_en, `PIA_RISE_G3, `PIA_RISE_G2, `PIA_RISE_G1};
    assign fall_en = {cfg.gpio_fall_en, `PIA_FALL_G3, 8'h00, `PIA_FALL_G1};
    assign used = {8'hFF, `PIA_USED_G3, `PIA_USED_G2, `PIA_USED_G1};
    assign wake_cap = {8'hFF, `PIA_WAKE_G3, `PIA_WAKE_G2, 8'h00};
    assign state_en = {24'hFFFFFF, is_on ? 8'hFF : ~`PIA_ONLY_ON_G1};
    assign edge_raw = ((rise_en & lvl & ~prev_r) | (fall_en & ~lvl & prev_r)) & state_en & {32{armed_r}};
    // Masking disables detection; the event is simply lost
    assign evt = edge_raw & ~cfg.mask & used;

    // ---------------------------------------------
    // Clear accesses
    // ---------------------------------------------
    logic clr_access;
    logic clr_eff;
    assign clr_access = cfg.clear_on_write ? req.wr : req.rd;
    // Back-to-back access to one register clears only once
    assign clr_eff = clr_access && !(last_valid_r && last_sel_r == req.sel);

    // Bits cleared by this access in a given group
    function automatic logic [7:0] pia_clr_bits(input logic [1:0] g, input logic eff, input pia_req_t r,
                                                input logic cow);
        pia_clr_bits = 8'h00;
        if (eff && r.sel == g)
        begin
            pia_clr_bits = cow ? r.wdata : 8'hFF;
        end
    endfunction : pia_clr_bits

    // ---------------------------------------------
    // Status and pending update, one slice per group
    // ---------------------------------------------
    pia_grp_t clr;
    pia_grp_t status_nxt;
    pia_grp_t pend_nxt;
    for (genvar g = 0; g < 4; g++)
    begin : g_grp
        assign clr[g] = pia_clr_bits(2'(g), clr_eff, req, cfg.clear_on_write);
        // A cleared bit with a stored repeat stays set; a new event wins over the clear
        assign status_nxt[g] = ((status_r[g] & ~clr[g]) | (pend_r[g] & clr[g]) | evt[g]) & used[g];
        // A repeat on an already set bit is kept only when storage is enabled
        assign pend_nxt[g] = ((pend_r[g] & ~clr[g]) | (evt[g] & status_r[g] & ~clr[g] & {8{cfg.pending_en}}))
                             & used[g];
    end

    // ---------------------------------------------
    // Line and wake combination
    // ---------------------------------------------
    logic line_act;
    logic wake_nxt;
    assign line_act = |status_r;
    // Remote wake and button wake whatever their mask says
    assign wake_nxt = (|(status_r & ~cfg.mask & wake_cap)) | (|(status_r[0] & `PIA_ALWAYS_G1))
                      | (|(edge_raw[0] & `PIA_ALWAYS_G1));

    // ---------------------------------------------
    // Sequential logic
    // ---------------------------------------------
    // Status, pending and edge history
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_r <= {4{`PIA_STATUS_RST}};
            pend_r <= '0;
            prev_r <= '0;
            armed_r <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            pend_r <= pend_nxt;
            prev_r <= lvl;
            armed_r <= 1'b1;
        end
    end

    // Button hold counter stops once it reaches the hold limit
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt_r <= '0;
        end
        else if (power_button)
        begin
            hold_cnt_r <= '0; // Released
        end
        else if (!hold_hit)
        begin
            hold_cnt_r <= hold_cnt_r + 32'd1;
        end
    end

    // Access tracking and read answer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_valid_r <= 1'b0;
            last_sel_r <= '0;
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= req.rd;
            if (req.rd)
            begin
                rdata_r <= status_r[req.sel]; // Value before the clear
            end
            if (req.rd || req.wr)
            begin
                last_valid_r <= 1'b1;
                last_sel_r <= req.sel;
            end
        end
    end

    // Output line and wake request; line idles inactive for low polarity
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_line_r <= 1'b1;
            wake_r <= 1'b0;
        end
        else
        begin
            int_line_r <= cfg.int_active_high ? line_act : ~line_act;
            wake_r <= wake_nxt;
        end
    end

    assign int_line = int_line_r;
    assign wake_request = wake_r;
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_vsys_edge;
        armed_r && $changed(supply_voltage_watch) && !cfg.mask[0][6] |=> status_r[0][6];
    endproperty
    a_vsys_edge: assert property (p_vsys_edge) else $error("supply watch edge not flagged");

    property p_hot_off;
        power_state == PS_OFF |=> !$rose(status_r[0][5]);
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("overheat flagged while off");

    property p_rwake_wake;
        armed_r && $fell(remote_wake_pin) && power_state != PS_OFF |=> wake_request;
    endproperty
    a_rwake_wake: assert property (p_rwake_wake) else $error("remote wake did not wake");

    property p_short_rise;
        armed_r && $rose(short_any) && !cfg.mask[1][6] |=> status_r[1][6];
    endproperty
    a_short_rise: assert property (p_short_rise) else $error("short not flagged");

    property p_tick_off;
        !cfg.rtc_tick_en |=> !$rose(status_r[1][1]);
    endproperty
    a_tick_off: assert property (p_tick_off) else $error("tick flagged while disabled");

    property p_line;
        (|status_r) && cfg.int_active_high |=> int_line;
    endproperty
    a_line: assert property (p_line) else $error("line not active with status set");

    property p_mask_hold;
        cfg.mask[3][0] && !status_r[3][0] |=> !status_r[3][0];
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("masked pin set status");

    property p_cow_clear;
        clr_eff && cfg.clear_on_write && req.wdata == 8'hFF && pend_r[req.sel] == 8'h00
            && evt[req.sel] == 8'h00 |=> status_r[$past(req.sel)] == 8'h00;
    endproperty
    a_cow_clear: assert property (p_cow_clear) else $error("write of all ones did not clear");

    property p_no_pend;
        !cfg.pending_en && pend_r == '0 |=> pend_r == '0;
    endproperty
    a_no_pend: assert property (p_no_pend) else $error("repeat stored while storage off");

endmodule : pia_aggregator

// ---- tb/pia_aggregator_tb.sv ----
// Testbench of the interrupt source aggregator
`timescale 1ns/1ns
`include "pia_defines.svh"
module pia_aggregator_tb
    import pia_pkg::*;
;
    // ------------------------------------------
    // Stimulus and observed outputs
    // ------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    pia_pstate_t power_state = PS_ACTIVE;
    pia_cfg_t cfg = '0;
    logic [21:0] src = 22'h000018; // Button and remote wake rest high
    pia_req_t req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic int_line;
    logic wake_request;
    logic [15:0] tbl [$]; // Source, group, expected status, wake
    int n_mismatch = 0;
    int checked = 0;
    int passes;
    always #25 ref_clk = ~ref_clk; // 20 MHz

    // ------------------------------------------
    // Design and host model
    // ------------------------------------------
    pia_aggregator #(.HOLD_STEP_CYC(8)) pia_aggregator_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .power_state(power_state), .cfg(cfg),
        .supply_voltage_watch(src[0]), .die_overheat(src[1]), .power_down_pin(src[2]),
        .remote_wake_pin(src[3]), .power_button(src[4]), .short_any(src[5]),
        .reset_in_pin(src[6]), .watchdog_expiry(src[7]), .rtc_tick(src[8]), .rtc_alarm(src[9]),
        .vbus_wake(src[10]), .adc_sw_done(src[11]), .adc_cmp_above(src[13:12]),
        .gpio_pins(src[21:14]), .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .int_line(int_line), .wake_request(wake_request)
    );
    pia_host_model pia_host_model_i (
        .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .int_line(int_line), .req(req)
    );

    // ------------------------------------------
    // Helpers
    // ------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : step

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1

    task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
        logic [7:0] d;
        pia_host_model_i.access(1'b0, sel, 8'h00, d);
        cmp8(d, exp);
    endtask : rd_chk

    task automatic wr(input logic [1:0] sel, input logic [7:0] data);
        logic [7:0] d;
        pia_host_model_i.access(1'b1, sel, data, d);
    endtask : wr

    function automatic logic [15:0] mk(input int i, input int g, input logic [7:0] x, input logic w);
        return {i[4:0], g[1:0], x, w};
    endfunction : mk

    // Flip one source, then check wake, line, the group and a neighbour (clear on read)
    // The neighbour is two groups away, so the next group's read is never a repeat access
    task automatic evt(input logic [15:0] e);
        src[e[15:11]] = ~src[e[15:11]];
        step(4);
        cmp1(wake_request, e[0]);
        cmp1(int_line, e[8:1] == 8'h00);
        rd_chk(e[10:9], e[8:1]);
        rd_chk(e[10:9] ^ 2'h2, 8'h00);
        step(2);
        cmp1(int_line, 1'b1);
    endtask : evt

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // ------------------------------------------
    // Hang guard
    // ------------------------------------------
    initial
    begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial
    begin
        cfg.gpio_rise_en = 8'hFF;
        cfg.gpio_fall_en = 8'hFF;
        cfg.hold_delay_setting = 2'h1; // Hold time of 16 cycles
        step(2);
        rst_n = 1'b1;
        step(2);
        cmp1(int_line, 1'b1);
        for (int g = 0; g < 4; g++)
            rd_chk(g[1:0], `PIA_STATUS_RST);
        cfg.rtc_tick_en = 1'b1;
        done("reset");
        tbl = '{
            mk(0, 0, 8'h40, 1'b0),
            mk(0, 0, 8'h40, 1'b0),
            mk(1, 0, 8'h20, 1'b0),
            mk(2, 0, 8'h10, 1'b0),
            mk(2, 0, 8'h10, 1'b0),
            mk(3, 0, 8'h08, 1'b1),
            mk(3, 0, 8'h00, 1'b0),
            mk(5, 1, 8'h40, 1'b1),
            mk(6, 1, 8'h10, 1'b0),
            mk(6, 1, 8'h00, 1'b0),
            mk(7, 1, 8'h04, 1'b0),
            mk(8, 1, 8'h02, 1'b1),
            mk(9, 1, 8'h01, 1'b1),
            mk(10, 2, 8'h80, 1'b1),
            mk(10, 2, 8'h80, 1'b1),
            mk(11, 2, 8'h04, 1'b1),
            mk(12, 2, 8'h01, 1'b1),
            mk(13, 2, 8'h02, 1'b1)
        };
        foreach (tbl[i])
            evt(tbl[i]);
        // Below-threshold direction: a falling result now flags the comparison
        cfg.cmp_below[0] = 1'b1;
        step(1);
        evt(mk(12, 2, 8'h01, 1'b1));
        for (int i = 0; i < 8; i++)
            evt(mk(14 + i, 3, 8'h01 << i, 1'b1));
        done("sources");
        // Button held past the limit adds the hold event
        src[4] = 1'b0;
        step(10);
        cmp1(wake_request, 1'b1);
        rd_chk(2'h0, 8'h02);
        rd_chk(2'h1, 8'h00);
        step(12);
        rd_chk(2'h0, 8'h04);
        src[4] = 1'b1;
        // Off state refuses overheat and remote wake
        power_state = PS_OFF;
        src[1] = 1'b0;
        src[3] = 1'b0;
        step(4);
        cmp1(wake_request, 1'b0);
        rd_chk(2'h0, 8'h00);
        power_state = PS_ACTIVE;
        src[3] = 1'b1;
        done("hold_and_off");
        // Masking keeps an old bit, drops new edges and removes the wake
        src[10] = ~src[10];
        step(4);
        cmp1(wake_request, 1'b1);
        cfg.mask[2][7] = 1'b1;
        step(3);
        cmp1(wake_request, 1'b0);
        src[10] = ~src[10];
        step(4);
        rd_chk(2'h2, 8'h80);
        rd_chk(2'h3, 8'h00);
        rd_chk(2'h2, 8'h00);
        cfg.mask[2][7] = 1'b0;
        // Masked remote wake still wakes for one cycle; a masked pin sets nothing
        cfg.mask[0][3] = 1'b1;
        cfg.mask[3][0] = 1'b1;
        src[3] = 1'b0;
        src[14] = 1'b0;
        step(1);
        cmp1(wake_request, 1'b1);
        step(3);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h3, 8'h00);
        src[3] = 1'b1;
        src[14] = 1'b1;
        step(1);
        cfg.mask[0][3] = 1'b0;
        cfg.mask[3][0] = 1'b0;
        done("mask");
        // Active-high line and per-bit clearing; a repeat access is refused
        cfg.int_active_high = 1'b1;
        cfg.clear_on_write = 1'b1;
        src[15:14] = 2'h0;
        step(4);
        cmp1(int_line, 1'b1);
        rd_chk(2'h3, 8'h03);
        wr(2'h3, 8'h01);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h3, 8'h03);
        rd_chk(2'h0, 8'h00);
        wr(2'h3, 8'h01);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h3, 8'h02);
        rd_chk(2'h0, 8'h00);
        wr(2'h3, 8'hFF);
        step(3);
        cmp1(int_line, 1'b0);
        cfg.int_active_high = 1'b0;
        cfg.clear_on_write = 1'b0;
        done("clear_on_write");
        // A repeat event needs a second pass only while pending storage is on
        for (int p = 1; p >= 0; p--)
        begin
            cfg.pending_en = p[0];
            src[15] = ~src[15];
            step(4);
            src[15] = ~src[15];
            step(4);
            pia_host_model_i.clear_all(passes);
            cmp8(8'(passes), 8'(p + 1));
        end
        done("pending");
        wrap_up();
    end
endmodule : pia_aggregator_tb

// ---- tb/pia_host_model.sv ----
// Host processor model: status register accesses and repeated clear passes
`timescale 1ns/1ns
module pia_host_model
    import pia_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Answers from the aggregator
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic int_line,
    // Status register access
    output pia_req_t req
);
    // ------------------------------------------
    // Access tasks
    // ------------------------------------------
    initial req = '0;

    // Request held over the taking edge; answer taken 5 ns after it
    task automatic access(input logic wr, input logic [1:0] sel, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(posedge ref_clk);
        #5;
        req = '{rd: !wr, wr: wr, sel: sel, wdata: wdata};
        @(posedge ref_clk);
        #5;
        rdata = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX; // No valid answer, no data
        req = '0; // Whole request released in one assignment
    endtask : access

    // Passes over all groups, four at most, while the line stays low; groups are visited in turn
    // because a second access to the same group does not clear it
    task automatic clear_all(output int passes);
        logic [7:0] d;
        passes = 0;
        repeat (4)
        begin
            if (int_line === 1'b0)
            begin
                for (int s = 0; s < 4; s++)
                    access(1'b0, s[1:0], 8'h00, d);
                passes++;
                repeat (2) @(posedge ref_clk);
                #5;
            end
        end
    endtask : clear_all
endmodule : pia_host_model
